// File: logic/gpio_defines.svh
// register indices, field positions, reset values and timing for the gpio block
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_A_DATA     10'h005
`define IDX_B_DATA     10'h006
`define IDX_C_DATA     10'h007
`define IDX_INT_CTRL   10'h00b
`define IDX_OPTION     10'h081
`define IDX_A_DIR      10'h085
`define IDX_B_DIR      10'h086
`define IDX_C_DIR      10'h087
`define IDX_ANALOG_CFG 10'h09f

// field positions
`define OPT_PULLUP_DIS_N_BIT 7
`define INT_CHANGE_FLAG_BIT  0
`define A_TIMER_CLK_BIT      4
`define A_SLAVE_SEL_BIT      5
`define B_EXT_IRQ_BIT        0
`define B_CHANGE_LO          4
`define ANALOG_CFG_W         3

// reset values
`define RST_OPTION     8'hff
`define RST_A_DIR      8'h3f
`define RST_B_DIR      8'hff
`define RST_C_DIR      8'hff
`define RST_LATCH      8'h00
`define RST_ANALOG_CFG 3'h0

// analog select masks over the first pin group
`define AN_MASK_ALL    8'h2f
`define AN_MASK_PART   8'h0b
`define AN_MASK_NONE   8'h00

// synchroniser depth in clock cycles
`define SYNC_STAGES 2

`endif

// File: logic/gpio_pkg.sv
// types shared by the gpio block
package gpio_pkg;

  // drive side of one pin group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  // peripheral takeover of the third pin group
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] out;
    logic [7:0] oe;
  } periph_ctl_t;

  // ahb-lite request as seen by the slave
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_t;

  typedef logic [7:0] byte_t;

endpackage : gpio_pkg

// File: logic/gpio_ports.sv
// three gpio pin groups with change detector, behind an ahb-lite slave
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.svh"

module gpio_ports
  import gpio_pkg::*;
#(
  parameter int A_WIDTH = 6
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire ahb_req_t    ahb_req,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // group a pins
  input  wire logic [A_WIDTH-1:0] pa_in,
  output pin_drive_t       pa_drive,
  // group b pins
  input  wire logic [7:0]  pb_in,
  output pin_drive_t       pb_drive,
  output logic      [7:0]  pb_pullup_en,
  // group c pins and peripheral takeover
  input  wire logic [7:0]  pc_in,
  output pin_drive_t       pc_drive,
  input  wire periph_ctl_t pc_periph,
  // alternate pin functions, change flag and wake request
  output logic             a4_timer_clock_pin,
  output logic             a5_slave_select_pin,
  output logic             b0_ext_irq_pin,
  output logic             change_irq_flag,
  output logic             wake_req
);

  // only the six-pin group a is served
  if (A_WIDTH != 6) begin : g_width_check
    $error("A_WIDTH must be 6");
  end

  // analog pin mask from the config field
  function automatic byte_t analog_mask(input logic [2:0] cfg);
    byte_t m;
    m = `AN_MASK_NONE;
    unique case (cfg)
      3'h0, 3'h1, 3'h2, 3'h3: m = `AN_MASK_ALL;
      3'h4, 3'h5:             m = `AN_MASK_PART;
      3'h6, 3'h7:             m = `AN_MASK_NONE;
    endcase
    return m;
  endfunction : analog_mask

  // word index of an aligned address, else an illegal index
  function automatic logic [9:0] word_index(input logic [31:0] a);
    logic [9:0] i;
    i = 10'h3ff;
    if (a[31:12] == 20'h00000 && a[1:0] == 2'b00) begin
      i = a[11:2];
    end
    return i;
  endfunction : word_index

  // registers
  byte_t      a_latch_q;
  byte_t      a_dir_q;
  byte_t      b_latch_q;
  byte_t      b_dir_q;
  byte_t      c_latch_q;
  byte_t      c_dir_q;
  byte_t      option_q;
  logic [2:0] analog_cfg_q;
  logic       flag_q;
  logic [3:0] b_old_q;

  // synchronisers
  byte_t a_meta_q;
  byte_t a_sync_q;
  byte_t b_meta_q;
  byte_t b_sync_q;
  byte_t c_meta_q;
  byte_t c_sync_q;

  // bus data phase
  logic       wr_pend_q;
  logic [9:0] wr_idx_q;
  logic [31:0] rdata_q;

  // bus decode
  logic       acc;
  logic       rd_acc;
  logic       wr_now;
  logic [9:0] acc_idx;
  byte_t      wr_byte;
  logic       b_touch;

  // write strobes, one per register
  logic       wr_a_data;
  logic       wr_a_dir;
  logic       wr_b_data;
  logic       wr_b_dir;
  logic       wr_c_data;
  logic       wr_c_dir;
  logic       wr_option;
  logic       wr_analog_cfg;
  logic       wr_int_ctrl;

  // pin views
  byte_t      a_pins;
  byte_t      a_mask;
  byte_t      c_dir_eff;
  byte_t      c_out_eff;
  logic [3:0] mismatch;
  logic       change_set;
  logic       pullup_disable_n;
  logic [3:0] b_upper_change_pins;
  byte_t      interrupt_control;

  // synchronise every pin before use
  // stage one may go metastable; only stage two is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_meta_q <= 8'h00;
      a_sync_q <= 8'h00;
      b_meta_q <= 8'h00;
      b_sync_q <= 8'h00;
      c_meta_q <= 8'h00;
      c_sync_q <= 8'h00;
    end else begin
      a_meta_q <= {2'b00, pa_in};
      a_sync_q <= a_meta_q;
      b_meta_q <= pb_in;
      b_sync_q <= b_meta_q;
      c_meta_q <= pc_in;
      c_sync_q <= c_meta_q;
    end
  end

  // bus request decode
  assign acc      = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  assign acc_idx  = word_index(ahb_req.haddr);
  assign rd_acc   = acc && !ahb_req.hwrite;
  assign wr_now   = wr_pend_q;
  assign wr_byte  = hwdata[7:0];
  assign b_touch  = acc && (acc_idx == `IDX_B_DATA);

  // raised in the data phase of a write
  assign wr_a_data     = wr_now && (wr_idx_q == `IDX_A_DATA);
  assign wr_a_dir      = wr_now && (wr_idx_q == `IDX_A_DIR);
  assign wr_b_data     = wr_now && (wr_idx_q == `IDX_B_DATA);
  assign wr_b_dir      = wr_now && (wr_idx_q == `IDX_B_DIR);
  assign wr_c_data     = wr_now && (wr_idx_q == `IDX_C_DATA);
  assign wr_c_dir      = wr_now && (wr_idx_q == `IDX_C_DIR);
  assign wr_option     = wr_now && (wr_idx_q == `IDX_OPTION);
  assign wr_analog_cfg = wr_now && (wr_idx_q == `IDX_ANALOG_CFG);
  assign wr_int_ctrl   = wr_now && (wr_idx_q == `IDX_INT_CTRL);

  // zero-wait, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // address phase held for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 10'h3ff;
    end else begin
      wr_pend_q <= acc && ahb_req.hwrite;
      wr_idx_q  <= acc_idx;
    end
  end

  // analog pins read as zero
  assign a_mask = analog_mask(analog_cfg_q);
  assign a_pins = a_sync_q & ~a_mask & 8'h3f;

  // read data captured at the address phase, pins not latches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_acc) begin
      unique case (acc_idx)
        `IDX_A_DATA:     rdata_q <= {24'h0, a_pins};
        `IDX_B_DATA:     rdata_q <= {24'h0, b_sync_q};
        `IDX_C_DATA:     rdata_q <= {24'h0, c_sync_q};
        `IDX_INT_CTRL:   rdata_q <= {24'h0, interrupt_control};
        `IDX_OPTION:     rdata_q <= {24'h0, option_q};
        `IDX_A_DIR:      rdata_q <= {24'h0, a_dir_q};
        `IDX_B_DIR:      rdata_q <= {24'h0, b_dir_q};
        `IDX_C_DIR:      rdata_q <= {24'h0, c_dir_q};
        `IDX_ANALOG_CFG: rdata_q <= {29'h0, analog_cfg_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // group a latch and direction, top two bits fixed zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_latch_q <= `RST_LATCH;
      a_dir_q   <= `RST_A_DIR;
    end else begin
      if (wr_a_data) begin
        a_latch_q <= wr_byte & 8'h3f;
      end
      if (wr_a_dir) begin
        a_dir_q <= wr_byte & 8'h3f;
      end
    end
  end

  // group b latch and direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_latch_q <= `RST_LATCH;
      b_dir_q   <= `RST_B_DIR;
    end else begin
      if (wr_b_data) begin
        b_latch_q <= wr_byte;
      end
      if (wr_b_dir) begin
        b_dir_q <= wr_byte;
      end
    end
  end

  // group c latch and direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_latch_q <= `RST_LATCH;
      c_dir_q   <= `RST_C_DIR;
    end else begin
      if (wr_c_data) begin
        c_latch_q <= wr_byte;
      end
      if (wr_c_dir) begin
        c_dir_q <= wr_byte;
      end
    end
  end

  // option and analog config; reset gives pull-ups off, analog pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      option_q     <= `RST_OPTION;
      analog_cfg_q <= `RST_ANALOG_CFG;
    end else begin
      if (wr_option) begin
        option_q <= wr_byte;
      end
      if (wr_analog_cfg) begin
        analog_cfg_q <= wr_byte[2:0];
      end
    end
  end

  // group a drivers: dir one floats; bit 4 open drain
  always_comb begin
    pa_drive.out = a_latch_q & 8'h3f;
    pa_drive.oe  = ~a_dir_q & 8'h3f;
    pa_drive.out[`A_TIMER_CLK_BIT] = 1'b0;
    pa_drive.oe[`A_TIMER_CLK_BIT]  = ~a_dir_q[`A_TIMER_CLK_BIT] & ~a_latch_q[`A_TIMER_CLK_BIT];
  end

  // timer clock and slave select taps
  assign a4_timer_clock_pin  = a_sync_q[`A_TIMER_CLK_BIT];
  assign a5_slave_select_pin = a_sync_q[`A_SLAVE_SEL_BIT];

  // group b drivers
  assign pb_drive.out = b_latch_q;
  assign pb_drive.oe  = ~b_dir_q;

  // pull-ups: global enable, gated off on outputs
  assign pullup_disable_n = option_q[`OPT_PULLUP_DIS_N_BIT];
  assign pb_pullup_en     = pullup_disable_n ? 8'h00 : b_dir_q;

  // external irq tap
  assign b0_ext_irq_pin = b_sync_q[`B_EXT_IRQ_BIT];

  // change compare over input pins b7..b4
  assign b_upper_change_pins = b_sync_q[`B_CHANGE_LO +: 4];
  assign mismatch            = (b_upper_change_pins ^ b_old_q) & b_dir_q[`B_CHANGE_LO +: 4];
  assign change_set = |mismatch;

  // polling reloads the reference but cannot hide a change
  // compare latch reloads on any group b data access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_old_q <= 4'h0;
    end else if (b_touch) begin
      b_old_q <= b_upper_change_pins;
    end
  end

  // flag: mismatch keeps setting, set beats a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else if (change_set) begin
      flag_q <= 1'b1;
    end else if (wr_int_ctrl) begin
      flag_q <= wr_byte[`INT_CHANGE_FLAG_BIT];
    end
  end

  assign change_irq_flag   = flag_q;
  assign interrupt_control = {7'h00, flag_q};
  assign wake_req        = flag_q;

  // group c peripheral override of data and direction
  assign c_out_eff = (pc_periph.sel & pc_periph.out) | (~pc_periph.sel & c_latch_q);
  assign c_dir_eff = (pc_periph.sel & ~pc_periph.oe) | (~pc_periph.sel & c_dir_q);

  assign pc_drive.out = c_out_eff;
  assign pc_drive.oe  = ~c_dir_eff;

endmodule : gpio_ports

`default_nettype wire

// File: sim/pins_model.sv
// board pins: block drive, board sources and pulls
`timescale 1ns/1ps
`default_nettype none
module pins_model
  import gpio_pkg::*;
(
  // block side
  input  wire pin_drive_t pa_drive,
  input  wire pin_drive_t pb_drive,
  input  wire pin_drive_t pc_drive,
  input  wire byte_t      pb_pullup_en,
  // board sources, en high drives
  input  wire byte_t      ext_v,
  input  wire byte_t      ext_en,
  // levels at the pins
  output logic [5:0]      pa_in,
  output byte_t           pb_in,
  output byte_t           pc_in
);
  byte_t a_lvl;
  // block drive wins; a and c pulled up on board, b pulled up where pb_pullup_en is set, else low
  assign a_lvl = (pa_drive.oe & pa_drive.out) | (~pa_drive.oe & ((ext_en & ext_v) | ~ext_en));
  assign pa_in = a_lvl[5:0];
  assign pb_in = (pb_drive.oe & pb_drive.out) | (~pb_drive.oe & ((ext_en & ext_v) | (~ext_en & pb_pullup_en)));
  assign pc_in = (pc_drive.oe & pc_drive.out) | (~pc_drive.oe & ((ext_en & ext_v) | ~ext_en));
endmodule : pins_model
`default_nettype wire

// File: sim/gpio_ports_monitor.sv
// concurrent checks on the gpio block ports
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_monitor
  import gpio_pkg::*;
#(
  parameter int A_WIDTH = 6
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // bus
  input  wire ahb_req_t          ahb_req,
  input  wire logic              hreadyout,
  input  wire logic              hresp,
  // pins
  input  wire logic [A_WIDTH-1:0] pa_in,
  input  wire pin_drive_t        pa_drive,
  input  wire logic [7:0]        pb_in,
  input  wire pin_drive_t        pb_drive,
  input  wire logic [7:0]        pb_pullup_en,
  input  wire pin_drive_t        pc_drive,
  input  wire periph_ctl_t       pc_periph,
  // alternate functions
  input  wire logic              a4_timer_clock_pin,
  input  wire logic              a5_slave_select_pin,
  input  wire logic              b0_ext_irq_pin,
  input  wire logic              change_irq_flag,
  input  wire logic              wake_req
);
  logic [1:0] up_q;
  logic       wr_q;
  // cycles since reset release, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // write accepted last edge, so data phase ends now
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1] & ahb_req.hwrite;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence flag_idle;
    change_irq_flag && !wr_q;
  endsequence
  sequence synced;
    up_q == 2'h3;
  endsequence
  a_drain_a: assert property (pa_drive.out[4] == 1'b0) else $error("a4 drives high");
  a_upper_a: assert property ({pa_drive.out[7:6], pa_drive.oe[7:6]} == 4'h0) else $error("a upper bits");
  pullup_out_a: assert property ((pb_pullup_en & pb_drive.oe) == 8'h0) else $error("pullup on output");
  c_periph_a: assert property (((pc_drive.out ^ pc_periph.out) & pc_periph.sel) == 8'h0
    && ((pc_drive.oe ^ pc_periph.oe) & pc_periph.sel) == 8'h0) else $error("c takeover");
  timer_sync_a: assert property (synced |-> a4_timer_clock_pin == $past(pa_in[4], 2))
    else $error("timer pin");
  ss_sync_a: assert property (synced |-> a5_slave_select_pin == $past(pa_in[5], 2))
    else $error("select pin");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus response");
  irq_sync_a: assert property (synced |-> b0_ext_irq_pin == $past(pb_in[0], 2)) else $error("irq pin");
  wake_flag_a: assert property (wake_req == change_irq_flag) else $error("wake");
  flag_hold_a: assert property (flag_idle |=> change_irq_flag) else $error("flag dropped");
endmodule : gpio_ports_monitor
bind gpio_ports gpio_ports_monitor #(.A_WIDTH(A_WIDTH)) mon_u (.*);
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the gpio block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.svh"
module testbench
  import gpio_pkg::*;
;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic [39:0] q = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [5:0]  pa_in;
  byte_t       pb_in, pc_in, pb_pullup_en;
  byte_t       ext_v = '0;
  byte_t       ext_en = '0;
  pin_drive_t  pa_drive, pb_drive, pc_drive;
  periph_ctl_t pc_periph = '0;
  logic        flag;
  int          fails = 0;
  int          compares = 0;
  always #12.5 hclk = ~hclk;
  gpio_ports dut_u (.hclk(hclk), .hresetn(hresetn), .ahb_req({q[39:1], hreadyout}), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pa_in(pa_in), .pa_drive(pa_drive),
    .pb_in(pb_in), .pb_drive(pb_drive), .pb_pullup_en(pb_pullup_en), .pc_in(pc_in),
    .pc_drive(pc_drive), .pc_periph(pc_periph), .a4_timer_clock_pin(), .a5_slave_select_pin(),
    .b0_ext_irq_pin(), .change_irq_flag(flag), .wake_req());
  pins_model pm_u (.pa_drive(pa_drive), .pb_drive(pb_drive), .pc_drive(pc_drive),
    .pb_pullup_en(pb_pullup_en), .ext_v(ext_v), .ext_en(ext_en), .pa_in(pa_in), .pb_in(pb_in),
    .pc_in(pc_in));
  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic phase;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      summarize();
    end
  endtask : phase
  task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] wd, output logic [31:0] rd);
    q <= {1'b1, 20'h0, i, 2'b00, 2'b10, w, 3'b010, 1'b0};
    phase();
    q <= '0;
    hwdata <= wd;
    phase();
    rd = hrdata;
    @(posedge hclk);
  endtask : bus
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, i, d, t);
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [31:0] e, input string nm);
    logic [31:0] t;
    repeat (3) @(posedge hclk);
    bus(1'b0, i, 32'h0, t);
    chk(nm, e, t);
  endtask : rd
  task automatic reset_values;
    rd(`IDX_OPTION, 32'hff, "option");
    rd(`IDX_A_DIR, 32'h3f, "a_dir");
    rd(`IDX_B_DIR, 32'hff, "b_dir");
    rd(`IDX_C_DIR, 32'hff, "c_dir");
    rd(`IDX_ANALOG_CFG, 32'h0, "cfg");
    rd(`IDX_A_DATA, 32'h10, "a_analog");
    rd(10'h0ff, 32'h0, "unmapped");
    chk("pullup_rst", 32'h0, pb_pullup_en);
  endtask : reset_values
  task automatic group_a;
    wr(`IDX_ANALOG_CFG, 32'h6);
    wr(`IDX_A_DIR, 32'hff);
    rd(`IDX_A_DIR, 32'h3f, "a_dir_w");
    wr(`IDX_A_DIR, 32'h0);
    wr(`IDX_A_DATA, 32'hff);
    chk("a_out", 32'h2f, pa_drive.out);
    chk("a_oe", 32'h2f, pa_drive.oe);
    wr(`IDX_A_DATA, 32'h0);
    chk("a_oe_low", 32'h3f, pa_drive.oe);
    rd(`IDX_A_DATA, 32'h0, "a_pins");
  endtask : group_a
  task automatic group_b;
    wr(`IDX_OPTION, 32'h7f);
    wr(`IDX_B_DIR, 32'h0f);
    chk("pullup", 32'h0f, pb_pullup_en);
    chk("b_oe", 32'hf0, pb_drive.oe);
  endtask : group_b
  task automatic change;
    wr(`IDX_B_DIR, 32'hff);
    rd(`IDX_B_DATA, 32'hff, "b_pins");
    wr(`IDX_INT_CTRL, 32'h0);
    chk("flag_clr", 32'h0, flag);
    @(posedge hclk) ext_en <= 8'h80;
    repeat (4) @(posedge hclk);
    chk("flag_set", 32'h1, flag);
    wr(`IDX_INT_CTRL, 32'h0);
    chk("flag_held", 32'h1, flag);
    rd(`IDX_B_DATA, 32'h7f, "b_pins2");
    wr(`IDX_INT_CTRL, 32'h0);
    chk("flag_clr2", 32'h0, flag);
    wr(`IDX_B_DIR, 32'h7f);
    wr(`IDX_B_DATA, 32'h0);
    wr(`IDX_INT_CTRL, 32'h0);
    wr(`IDX_B_DATA, 32'h80);
    repeat (4) @(posedge hclk);
    chk("flag_excl", 32'h0, flag);
  endtask : change
  task automatic group_c;
    wr(`IDX_C_DIR, 32'h0);
    wr(`IDX_C_DATA, 32'ha5);
    @(posedge hclk) pc_periph <= {8'h0f, 8'h03, 8'h05};
    @(posedge hclk);
    chk("c_out", 32'ha3, pc_drive.out);
    chk("c_oe", 32'hf5, pc_drive.oe);
    rd(`IDX_C_DATA, 32'hab, "c_pins");
  endtask : group_c
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    reset_values();
    group_a();
    group_b();
    change();
    group_c();
    summarize();
  end
endmodule : testbench
`default_nettype wire
